// *** hdl/iecc_pkg.sv ***
// constants, types and field arithmetic for the interleaved rs codec
// assumes a single clock domain and an axi4-lite register port
package iecc_pkg;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_LEN = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_SYN = 4'hc;

  // control field positions
  localparam int CTL_ARM = 0;
  localparam int CTL_WRT = 1;
  localparam int CTL_CRC = 2;
  localparam int CTL_DMA = 3;
  localparam int CTL_SSO = 4;
  localparam int CTL_DEG_LO = 8;
  localparam int CTL_ILV_LO = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [11:0] LEN_RST = 12'h000;

  // status field positions
  localparam int STA_PH_LO = 0;
  localparam int STA_ERR = 4;
  localparam int STA_SYN = 5;
  localparam int STA_ILV_LO = 8;
  localparam int STA_CNT_LO = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int ILV_MAX = 10;
  localparam logic [11:0] CRC_BYTES = 12'h004;
  localparam logic [7:0] GF_LOW = 8'h2d; // x^8 = x^5+x^3+x^2+1
  localparam logic [1:0] DEG_4 = 2'h0;
  localparam logic [1:0] DEG_8 = 2'h1;
  localparam logic [1:0] DEG_16 = 2'h2;

  // generator coefficients below the leading one, index = power of x
  localparam logic [15:0][7:0] G16 = {8'h5c, 8'ha0, 8'h56, 8'h0b, 8'h44,
    8'h02, 8'h01, 8'ha7, 8'h01, 8'h02, 8'h44, 8'h0b, 8'h56, 8'ha0, 8'h5c,
    8'h01};
  localparam logic [7:0][7:0] G8 = {8'h72, 8'h47, 8'h56, 8'h82, 8'h56,
    8'h47, 8'h72, 8'h01};
  localparam logic [3:0][7:0] G4 = {8'h40, 8'h3d, 8'h40, 8'h01};
  localparam logic [3:0][7:0] GCRC = {8'he8, 8'hc2, 8'h23, 8'hc6};

  typedef enum logic [2:0] {PH_IDLE, PH_DATA, PH_CRC, PH_RED, PH_SCRC,
    PH_SRED} iecc_phase_t;

  // multiply in gf(256) by shift and conditional reduce
  function automatic logic [7:0] gf_mul(input logic [7:0] a,
                                        input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        p = p ^ x;
      x = x[7] ? ((x << 1) ^ GF_LOW) : (x << 1);
    end
    return p;
  endfunction : gf_mul

  function automatic logic [4:0] deg_bytes(input logic [1:0] sel);
    case (sel)
      DEG_8: return 5'd8;
      DEG_16: return 5'd16;
      default: return 5'd4;
    endcase
  endfunction : deg_bytes

  // interleave code 0..6 selects 1,2,3,4,5,8,10; code 7 falls back to 1
  function automatic logic [3:0] ilv_count(input logic [2:0] code);
    case (code)
      3'h1: return 4'd2;
      3'h2: return 4'd3;
      3'h3: return 4'd4;
      3'h4: return 4'd5;
      3'h5: return 4'd8;
      3'h6: return 4'd10;
      default: return 4'd1;
    endcase
  endfunction : ilv_count

endpackage : iecc_pkg

// *** hdl/iecc_codec.sv ***
// interleaved reed-solomon ecc and crc coding core with axi4-lite registers
// assumes byte stream ports on aclk and an asynchronous dma acknowledge pin
//
// Summary of operation
// - syndromes leave by register read or by dma request/acknowledge pins.
// - read mode forms syndromes while received redundancy bytes stream in.
// - degree-16 code makes sixteen redundancy bytes per interleave.
// - crc is 32 bits with one polynomial for every ecc degree.
// - degree-4 and degree-8 codes make four and eight bytes per interleave.
// - interleave factors are 1, 2, 3, 4, 5, 8 and 10 only.
// - redundancy and syndrome count equals degree times interleave factor.
// - crc adds four bytes per block when enabled, none otherwise.
// - bytes rotate over interleaves; crc continues rotation and is ecc-covered.
// - output order is data, then crc bytes, then redundancy bytes.
// - all arithmetic is in gf(256) from x^8+x^5+x^3+x^2+1.
// - code element alpha^i is beta^i raised to the 88th power.
// - degree-16 generator uses the fixed sixteen coefficient set.
// - degree-8 generator uses the fixed eight coefficient set.
// - degree-4 generator uses the fixed four coefficient set.
// - every ecc redundancy byte is inverted before output.
// - all encoder shift registers start at zero each block.
// - crc is a degree-4 rs code, four bytes per sector.
// - crc input is the xor of data bytes across interleaves.
// - crc bytes go out without inversion.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
module iecc_codec (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic syndrome_dma_request,
  input wire logic syndrome_dma_acknowledge,
  output logic [7:0] syndrome_dma_data
);

  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff, ctrl_ff;
  logic [11:0] len_ff, cnt_ff, limit;
  iecc_pkg::iecc_phase_t phase_ff, nxt_phase;
  logic [3:0] ilv_ff, n_ilv;
  logic [4:0] n_deg;
  logic [7:0] red_total, acc_ff, nxt_acc, ecc_top, syn_byte;
  logic [7:0] ecc_in, crc_in, out_data_ff, dma_data_ff;
  logic [3:0][7:0] crc_ff;
  logic [15:0][7:0] ecc_ff [iecc_pkg::ILV_MAX];
  logic ecc_go, crc_go, in_ready_ff, out_valid_ff, req_ff, err_ff;
  logic ack_s1_ff, ack_s2_ff, ack_s3_ff;
  logic arm, wr, crc_en, dma_en, sso, in_fire, slot_free, emit_w;
  logic syn_ph, pio_pop, dma_pop, pop, ev, ph_last, blk_start, wr_en, rd_en;

  // one shift step of the selected remainder register
  function automatic logic [15:0][7:0] ecc_step(input logic [15:0][7:0] r,
      input logic [7:0] din, input logic [1:0] dsel);
    logic [15:0][7:0] s;
    logic [4:0] d;
    logic [7:0] fb;
    logic [15:0][7:0] g;
    d = iecc_pkg::deg_bytes(dsel);
    fb = din ^ r[d - 5'd1];
    case (dsel)
      iecc_pkg::DEG_16: g = iecc_pkg::G16;
      iecc_pkg::DEG_8: g = {64'h0, iecc_pkg::G8};
      default: g = {96'h0, iecc_pkg::G4};
    endcase
    s = '0;
    s[0] = iecc_pkg::gf_mul(fb, g[0]);
    for (int k = 1; k < 16; k++)
    begin
      if (5'(k) < d)
        s[k] = r[k - 1] ^ iecc_pkg::gf_mul(fb, g[k]);
    end
    return s;
  endfunction : ecc_step

  // configuration decode
  assign arm = ctrl_ff[iecc_pkg::CTL_ARM];
  assign wr = ctrl_ff[iecc_pkg::CTL_WRT];
  assign crc_en = ctrl_ff[iecc_pkg::CTL_CRC];
  assign dma_en = ctrl_ff[iecc_pkg::CTL_DMA];
  assign sso = ctrl_ff[iecc_pkg::CTL_SSO];
  assign n_ilv = iecc_pkg::ilv_count(ctrl_ff[iecc_pkg::CTL_ILV_LO +: 3]);
  assign n_deg = iecc_pkg::deg_bytes(ctrl_ff[iecc_pkg::CTL_DEG_LO +: 2]);
  assign red_total = 8'(n_deg * n_ilv);

  // stream and syndrome handshakes
  assign in_fire = in_valid && in_ready_ff;
  assign slot_free = !out_valid_ff || out_ready;
  assign emit_w = wr && slot_free &&
                  (phase_ff == iecc_pkg::PH_CRC || phase_ff == iecc_pkg::PH_RED);
  assign ecc_top = ecc_ff[ilv_ff][n_deg - 5'd1];
  assign syn_ph = phase_ff == iecc_pkg::PH_SCRC || phase_ff == iecc_pkg::PH_SRED;
  assign syn_byte = (phase_ff == iecc_pkg::PH_SCRC) ? crc_ff[3] : ecc_top;
  assign wr_en = awready_ff;
  assign rd_en = arready_ff;
  assign pio_pop = rd_en && s_axi_araddr == iecc_pkg::OFS_SYN && syn_ph &&
                   !dma_en;
  assign dma_pop = ack_s2_ff && !ack_s3_ff && req_ff && syn_ph;
  assign pop = pio_pop || dma_pop;

  // route each accepted or emitted byte into the ecc and crc registers
  always_comb
  begin
    ecc_go = 1'b0;
    crc_go = 1'b0;
    ecc_in = 8'h00;
    crc_in = 8'h00;
    nxt_acc = acc_ff;
    case (phase_ff)
      iecc_pkg::PH_DATA:
        if (in_fire)
        begin
          ecc_go = 1'b1;
          ecc_in = in_data;
          nxt_acc = (ilv_ff == 4'd0) ? in_data : (acc_ff ^ in_data);
          crc_go = ilv_ff == n_ilv - 4'd1 || cnt_ff == len_ff - 12'd1;
          crc_in = nxt_acc;
        end
      iecc_pkg::PH_CRC:
        if (wr ? emit_w : in_fire)
        begin
          // crc bytes keep the rotation and feed that interleave's ecc
          ecc_go = 1'b1;
          crc_go = 1'b1;
          ecc_in = wr ? crc_ff[3] : in_data;
          crc_in = wr ? crc_ff[3] : in_data;
        end
      iecc_pkg::PH_RED:
        if (wr ? emit_w : in_fire)
        begin
          ecc_go = 1'b1;
          ecc_in = wr ? ecc_top : ~in_data; // undo the inversion on read
        end
      iecc_pkg::PH_SCRC:
        if (pop)
        begin
          crc_go = 1'b1;
          crc_in = crc_ff[3];
        end
      iecc_pkg::PH_SRED:
        if (pop)
        begin
          ecc_go = 1'b1;
          ecc_in = ecc_top;
        end
      default:
        ecc_go = 1'b0;
    endcase
  end

  // phase sequencing: count events against the length of each phase
  assign ev = ecc_go || crc_go;
  always_comb
  begin
    case (phase_ff)
      iecc_pkg::PH_DATA: limit = len_ff;
      iecc_pkg::PH_CRC, iecc_pkg::PH_SCRC: limit = iecc_pkg::CRC_BYTES;
      default: limit = {4'h0, red_total};
    endcase
  end
  assign ph_last = ev && cnt_ff == limit - 12'd1;
  always_comb
  begin
    nxt_phase = phase_ff;
    case (phase_ff)
      iecc_pkg::PH_IDLE:
        if (arm)
          nxt_phase = iecc_pkg::PH_DATA;
      iecc_pkg::PH_DATA:
        if (ph_last)
          nxt_phase = crc_en ? iecc_pkg::PH_CRC : iecc_pkg::PH_RED;
      iecc_pkg::PH_CRC:
        if (ph_last)
          nxt_phase = iecc_pkg::PH_RED;
      iecc_pkg::PH_RED:
        if (ph_last && wr)
          nxt_phase = sso ? iecc_pkg::PH_IDLE : iecc_pkg::PH_DATA;
        else if (ph_last)
          nxt_phase = crc_en ? iecc_pkg::PH_SCRC : iecc_pkg::PH_SRED;
      iecc_pkg::PH_SCRC:
        if (ph_last)
          nxt_phase = iecc_pkg::PH_SRED;
      iecc_pkg::PH_SRED:
        if (ph_last)
          nxt_phase = sso ? iecc_pkg::PH_IDLE : iecc_pkg::PH_DATA;
      default:
        nxt_phase = iecc_pkg::PH_IDLE;
    endcase
    if (!arm)
      nxt_phase = iecc_pkg::PH_IDLE; // clearing arm aborts the block
  end
  assign blk_start = nxt_phase == iecc_pkg::PH_DATA &&
                     (phase_ff != iecc_pkg::PH_DATA || ph_last);

  // phase, byte counter and interleave pointer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_ff <= iecc_pkg::PH_IDLE;
      cnt_ff <= 12'h000;
      ilv_ff <= 4'h0;
      acc_ff <= 8'h00;
    end
    else
    begin
      phase_ff <= nxt_phase;
      acc_ff <= nxt_acc;
      if (nxt_phase != phase_ff || ph_last)
        cnt_ff <= 12'h000;
      else if (ev)
        cnt_ff <= cnt_ff + 12'd1;
      // syndromes are read out from interleave zero; encoding rotates on
      if (blk_start || nxt_phase == iecc_pkg::PH_IDLE ||
          nxt_phase == iecc_pkg::PH_SRED && phase_ff != iecc_pkg::PH_SRED)
        ilv_ff <= 4'h0;
      else if (ecc_go)
        ilv_ff <= (ilv_ff == n_ilv - 4'd1) ? 4'h0 : ilv_ff + 4'd1;
    end
  end

  // remainder registers, cleared at every block start
  always_ff @(posedge aclk)
  begin
    if (!aresetn || blk_start)
    begin
      for (int i = 0; i < iecc_pkg::ILV_MAX; i++)
        ecc_ff[i] <= '0;
      crc_ff <= '0;
    end
    else
    begin
      if (ecc_go)
        ecc_ff[ilv_ff] <= ecc_step(ecc_ff[ilv_ff], ecc_in,
                                   ctrl_ff[iecc_pkg::CTL_DEG_LO +: 2]);
      if (crc_go)
      begin
        // degree-4 division, fixed whatever the ecc degree is
        crc_ff[3] <= crc_ff[2] ^ iecc_pkg::gf_mul(crc_in ^ crc_ff[3],
                                                  iecc_pkg::GCRC[3]);
        crc_ff[2] <= crc_ff[1] ^ iecc_pkg::gf_mul(crc_in ^ crc_ff[3],
                                                  iecc_pkg::GCRC[2]);
        crc_ff[1] <= crc_ff[0] ^ iecc_pkg::gf_mul(crc_in ^ crc_ff[3],
                                                  iecc_pkg::GCRC[1]);
        crc_ff[0] <= iecc_pkg::gf_mul(crc_in ^ crc_ff[3],
                                      iecc_pkg::GCRC[0]);
      end
    end
  end

  // output byte slot; in write mode input is taken only when the slot will be empty
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_valid_ff <= 1'b0;
      out_data_ff <= 8'h00;
      in_ready_ff <= 1'b0;
    end
    else
    begin
      if (wr && phase_ff == iecc_pkg::PH_DATA && in_fire)
      begin
        out_valid_ff <= 1'b1;
        out_data_ff <= in_data;
      end
      else if (emit_w)
      begin
        out_valid_ff <= 1'b1;
        out_data_ff <= (phase_ff == iecc_pkg::PH_CRC) ? crc_ff[3]
                                                      : ~ecc_top;
      end
      else if (out_ready)
        out_valid_ff <= 1'b0;
      // one accept every other cycle keeps counters ahead of the stream
      in_ready_ff <= arm && !in_fire && (phase_ff == iecc_pkg::PH_DATA ||
                     !wr && (phase_ff == iecc_pkg::PH_CRC ||
                     phase_ff == iecc_pkg::PH_RED)) && (!wr || slot_free);
    end
  end

  // dma handshake; the ack pin is synchronised before any use
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
      req_ff <= 1'b0;
      dma_data_ff <= 8'h00;
      err_ff <= 1'b0;
    end
    else
    begin
      ack_s1_ff <= syndrome_dma_acknowledge;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
      req_ff <= dma_en && syn_ph && !ack_s2_ff && !dma_pop;
      dma_data_ff <= syn_ph ? syn_byte : 8'h00;
      if (pop && syn_byte != 8'h00)
        err_ff <= 1'b1; // any nonzero syndrome marks the block in error
      else if (blk_start)
        err_ff <= 1'b0; // a same-cycle set wins so no error is lost
    end
  end

  // axi4-lite write channel; address and data are taken together
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= iecc_pkg::RESP_OKAY;
      ctrl_ff <= iecc_pkg::CTRL_RST;
      len_ff <= iecc_pkg::LEN_RST;
    end
    else
    begin
      awready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
      wready_ff <= s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
      if (ph_last && sso && (wr && phase_ff == iecc_pkg::PH_RED ||
          phase_ff == iecc_pkg::PH_SRED))
        ctrl_ff[iecc_pkg::CTL_ARM] <= 1'b0; // single block then disarm
      if (wr_en)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff <= iecc_pkg::RESP_OKAY;
        case (s_axi_awaddr)
          iecc_pkg::OFS_CTRL:
            for (int b = 0; b < 4; b++)
            begin
              if (s_axi_wstrb[b])
                ctrl_ff[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
            end
          iecc_pkg::OFS_LEN:
          begin
            if (s_axi_wstrb[0])
              len_ff[7:0] <= s_axi_wdata[7:0];
            if (s_axi_wstrb[1])
              len_ff[11:8] <= s_axi_wdata[11:8];
          end
          iecc_pkg::OFS_STAT, iecc_pkg::OFS_SYN:
            bresp_ff <= iecc_pkg::RESP_OKAY; // read-only, write ignored
          default:
            bresp_ff <= iecc_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // axi4-lite read channel; a syndrome read pops one byte unless dma is enabled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= iecc_pkg::RESP_OKAY;
    end
    else
    begin
      arready_ff <= s_axi_arvalid && !arready_ff && !rvalid_ff;
      if (rd_en)
      begin
        rvalid_ff <= 1'b1;
        rresp_ff <= iecc_pkg::RESP_OKAY;
        rdata_ff <= 32'h0000_0000;
        case (s_axi_araddr)
          iecc_pkg::OFS_CTRL: rdata_ff <= ctrl_ff;
          iecc_pkg::OFS_LEN: rdata_ff <= {20'h00000, len_ff};
          iecc_pkg::OFS_STAT:
          begin
            rdata_ff[iecc_pkg::STA_PH_LO +: 3] <= phase_ff;
            rdata_ff[iecc_pkg::STA_ERR] <= err_ff;
            rdata_ff[iecc_pkg::STA_SYN] <= syn_ph;
            rdata_ff[iecc_pkg::STA_ILV_LO +: 4] <= ilv_ff;
            rdata_ff[iecc_pkg::STA_CNT_LO +: 12] <= cnt_ff;
          end
          iecc_pkg::OFS_SYN: rdata_ff <= {23'h000000, pio_pop,
                                          pio_pop ? syn_byte : 8'h00};
          default: rresp_ff <= iecc_pkg::RESP_SLVERR;
        endcase
      end
      else if (s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = out_data_ff;
  assign syndrome_dma_request = req_ff;
  assign syndrome_dma_data = dma_data_ff;

  // checks on the coding sequence
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ilv_range: assert property (ilv_ff < n_ilv)
    else $error("interleave pointer beyond factor");
  a_red_invert: assert property (emit_w && phase_ff == iecc_pkg::PH_RED
    |=> out_data_ff == ~$past(ecc_top))
    else $error("redundancy byte not inverted");
  a_crc_plain: assert property (emit_w && phase_ff == iecc_pkg::PH_CRC
    |=> out_data_ff == $past(crc_ff[3]))
    else $error("crc byte altered on output");
  a_crc_four: assert property (phase_ff == iecc_pkg::PH_CRC |->
    cnt_ff < iecc_pkg::CRC_BYTES)
    else $error("crc phase exceeded four bytes");
  a_red_count: assert property (phase_ff == iecc_pkg::PH_RED && ph_last
    |=> phase_ff != iecc_pkg::PH_RED)
    else $error("redundancy phase overran count");
  a_block_clear: assert property (blk_start |=> crc_ff == '0 &&
    ecc_ff[0] == '0)
    else $error("encoder not zero at block start");
  a_data_pass: assert property (wr && phase_ff == iecc_pkg::PH_DATA &&
    in_fire |=> out_valid_ff && out_data_ff == $past(in_data))
    else $error("data byte not passed through");
  a_dma_req: assert property (req_ff |-> $past(dma_en && syn_ph))
    else $error("dma request outside syndrome phase");
  a_out_hold: assert property (out_valid_ff && !out_ready |=>
    out_valid_ff && $stable(out_data_ff))
    else $error("output byte dropped under stall");

endmodule : iecc_codec

// *** tb/iecc_far_end.sv ***
// far-side model: byte sink with random stalls, syndrome dma acknowledger
// assumes the codec's stream and dma pins on aclk; bytes land in queues
module iecc_far_end (
  input wire logic aclk,
  input wire logic [7:0] out_data,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic syndrome_dma_request,
  input wire logic [7:0] syndrome_dma_data,
  output logic syndrome_dma_acknowledge
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [7:0] syn[$];

  // stall about a third of the cycles so the codec must hold its output
  initial
  begin
    out_ready = 1'b0;
    forever
    begin
      @(posedge aclk);
      if (out_valid && out_ready)
        got.push_back(out_data);
      out_ready <= ($urandom % 3) != 0;
    end
  end

  // take the byte, then hold ack until request drops
  initial
  begin
    syndrome_dma_acknowledge = 1'b0;
    forever
    begin
      @(posedge aclk);
      if (syndrome_dma_request && !syndrome_dma_acknowledge)
      begin
        repeat ($urandom % 3) @(posedge aclk);
        syn.push_back(syndrome_dma_data);
        syndrome_dma_acknowledge <= 1'b1;
      end
      else if (!syndrome_dma_request)
        syndrome_dma_acknowledge <= 1'b0;
    end
  end
endmodule : iecc_far_end

// *** tb/iecc_codec_bench.sv ***
// bench for the interleaved rs codec: axi set-up, byte streams, reference
// codewords built in functions; assumes the codec's axi map and stream order
module iecc_codec_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int G16[17] = '{1, 92, 160, 86, 11, 68, 2, 1, 167, 1, 2, 68, 11,
    86, 160, 92, 1};
  localparam int G8[9] = '{1, 114, 71, 86, 130, 86, 71, 114, 1};
  localparam int G4[5] = '{1, 64, 61, 64, 1};
  localparam int GCR[5] = '{1, 232, 194, 35, 198};
  localparam int NI[7] = '{1, 2, 3, 4, 5, 8, 10};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, in_valid, in_ready;
  logic out_valid, out_ready, syndrome_dma_request, syndrome_dma_acknowledge;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] in_data, out_data, syndrome_dma_data;
  int mismatches = 0;
  int compares = 0;

  iecc_codec dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .in_data, .in_valid, .in_ready, .out_data, .out_valid, .out_ready,
    .syndrome_dma_request, .syndrome_dma_acknowledge, .syndrome_dma_data);
  iecc_far_end far (.aclk, .out_data, .out_valid, .out_ready,
    .syndrome_dma_request, .syndrome_dma_data, .syndrome_dma_acknowledge);

  // field product, reduced by x^8+x^5+x^3+x^2+1
  function automatic logic [7:0] gm(logic [7:0] a, logic [7:0] b);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        p ^= a;
      a = a[7] ? ((a << 1) ^ 8'h2d) : (a << 1);
    end
    return p;
  endfunction : gm

  // coefficient of x^k; degree 0 selects the crc generator
  function automatic logic [7:0] gc(int n, int k);
    case (n)
      16: return 8'(G16[16 - k]);
      8: return 8'(G8[8 - k]);
      4: return 8'(G4[4 - k]);
      default: return 8'(GCR[4 - k]);
    endcase
  endfunction : gc

  // one division step of a remainder register
  function automatic void step(inout logic [7:0] r[16], input int n,
                               input logic [7:0] b);
    int m;
    logic [7:0] fb;
    m = (n == 0) ? 4 : n;
    fb = b ^ r[m - 1];
    for (int k = m - 1; k > 0; k--)
      r[k] = r[k - 1] ^ gm(gc(n, k), fb);
    r[0] = gm(gc(n, 0), fb);
  endfunction : step

  // appends the full written block: data, crc, inverted ecc
  function automatic void enc(input logic [7:0] d[$], input int n, ni,
                              input bit crc, inout logic [7:0] o[$]);
    logic [7:0] e[10][16];
    logic [7:0] c[16];
    logic [7:0] x;
    int p[10];
    int l;
    e = '{default: 8'h00};
    c = '{default: 8'h00};
    p = '{default: 0};
    x = 8'h00;
    l = d.size();
    foreach (d[j])
    begin
      o.push_back(d[j]);
      step(e[j % ni], n, d[j]);
      x ^= d[j];
      if (j % ni == ni - 1 || j == l - 1)
      begin
        step(c, 0, x);
        x = 8'h00;
      end
    end
    for (int k = 0; crc && k < 4; k++)
    begin
      o.push_back(c[3 - k]);
      step(e[(l + k) % ni], n, c[3 - k]);
    end
    l += crc ? 4 : 0;
    for (int r = 0; r < n * ni; r++)
    begin
      o.push_back(~e[(l + r) % ni][n - 1 - p[(l + r) % ni]]);
      p[(l + r) % ni]++;
    end
  endfunction : enc

  function automatic logic [31:0] ctl(int dg, ic, bit crc, wr, dma, sso);
    return 32'(1 | (wr << iecc_pkg::CTL_WRT) | (crc << iecc_pkg::CTL_CRC) |
      (dma << iecc_pkg::CTL_DMA) | (sso << iecc_pkg::CTL_SSO) |
      (dg << iecc_pkg::CTL_DEG_LO) | (ic << iecc_pkg::CTL_ILV_LO));
  endfunction : ctl

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // axi writes and reads; bready and rready stay high throughout
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 99; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    chk({s_axi_bvalid, s_axi_bresp}, {1'b1, (a[1:0] != 2'h0) ?
      iecc_pkg::RESP_SLVERR : iecc_pkg::RESP_OKAY});
  endtask : axw

  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 99; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    chk(s_axi_rvalid, 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axr

  task automatic feed(input logic [7:0] d[$]);
    int n;
    foreach (d[j])
    begin
      in_data <= d[j];
      in_valid <= 1'b1;
      n = 0;
      do
      begin
        @(posedge aclk);
        n++;
      end
      while (!in_ready && n < 999);
    end
    in_valid <= 1'b0;
  endtask : feed

  // write mode, nb blocks; single-block only when nb is one
  task automatic run_wr(input int dg, ic, len, nb, input bit crc);
    logic [7:0] d[$], q[$], o[$];
    far.got.delete();
    for (int b = 0; b < nb; b++)
    begin
      q.delete();
      repeat (len) q.push_back(8'($urandom));
      enc(q, 4 << dg, NI[ic], crc, o);
      d = {d, q};
    end
    axw(iecc_pkg::OFS_LEN, 32'(len));
    axw(iecc_pkg::OFS_CTRL, ctl(dg, ic, crc, 1, 0, nb == 1));
    feed(d);
    for (int k = 0; k < 4000 && far.got.size() < o.size(); k++)
      @(posedge aclk);
    chk(far.got.size(), o.size());
    foreach (o[j])
      chk(far.got[j], o[j]);
    axw(iecc_pkg::OFS_CTRL, 32'h0);
  endtask : run_wr

  // read mode; a flipped data bit must leave nonzero syndromes
  task automatic run_rd(input int dg, ic, len, input bit crc, dma, flip);
    logic [7:0] q[$], o[$], s[$];
    logic [31:0] r;
    logic [1:0] rs;
    logic [7:0] acc;
    int ns;
    ns = (4 << dg) * NI[ic] + (crc ? 4 : 0);
    repeat (len) q.push_back(8'($urandom));
    enc(q, 4 << dg, NI[ic], crc, o);
    if (flip)
      o[len / 2] ^= 8'h01 << ($urandom % 8);
    far.syn.delete();
    axw(iecc_pkg::OFS_LEN, 32'(len));
    axw(iecc_pkg::OFS_CTRL, ctl(dg, ic, crc, 0, dma, 1));
    feed(o);
    for (int k = 0; k < 3000 && s.size() < ns; k++)
      if (dma)
      begin
        @(posedge aclk);
        s = far.syn;
      end
      else
      begin
        axr(iecc_pkg::OFS_SYN, r, rs);
        if (r[8])
          s.push_back(r[7:0]);
      end
    chk(s.size(), ns);
    acc = 8'h00;
    foreach (s[j])
      acc |= s[j];
    chk(acc != 8'h00, flip);
    for (int k = 0; k < 50; k++)
    begin
      axr(iecc_pkg::OFS_STAT, r, rs);
      if (r[2:0] == 3'h0)
        break;
    end
    chk(r[iecc_pkg::STA_ERR], flip);
    axr(iecc_pkg::OFS_SYN, r, rs);
    chk(r[8], 1'b0);
  endtask : run_rd

  task automatic test_done;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  // free-running 10 mhz clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // a hang ends the run through the same closing task
  initial
  begin
    repeat (80000) @(posedge aclk);
    mismatches++;
    test_done();
  end

  // reset, register defaults, then every degree and interleave factor
  initial
  begin
    logic [31:0] r;
    logic [1:0] rs;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, in_valid} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, in_data} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
    void'($urandom(32'h48b984e4));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(iecc_pkg::OFS_CTRL, r, rs);
    chk(r, iecc_pkg::CTRL_RST);
    axr(iecc_pkg::OFS_LEN, r, rs);
    chk(r, {20'h0, iecc_pkg::LEN_RST});
    chk(rs, iecc_pkg::RESP_OKAY);
    axr(4'h2, r, rs);
    chk(rs, iecc_pkg::RESP_SLVERR);
    axw(4'h6, 32'h0);
    for (int dg = 0; dg < 3; dg++)
      for (int ic = 0; ic < 7; ic++)
        run_wr(dg, ic, (dg + ic == 8) ? 1 : 1 + $urandom % 40, 1 + ic % 2,
          1'($urandom));
    run_wr(2, 0, 235, 1, 1);
    run_rd(1, 3, 33, 1, 0, 0);
    run_rd(1, 3, 33, 1, 0, 1);
    run_rd(2, 4, 50, 1, 1, 0);
    run_rd(0, 6, 25, 0, 1, 1);
    test_done();
  end
endmodule : iecc_codec_bench
